/* e1_nat_pkg.sv */
// constants for the E1 national-bit auto-response block
// assumes one TS0 overhead word per non-FAS frame, MSB-first sequences
package e1_nat_pkg;
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 8;
    localparam int          POS_W      = 3;
    localparam int          RUN_DEF    = 8;
    // register offsets
    localparam logic [7:0]  OFS_SEL    = 8'h30;
    localparam logic [7:0]  OFS_CTRL1  = 8'h31;
    localparam logic [7:0]  OFS_CTRL2  = 8'h32;
    localparam logic [7:0]  OFS_SA5    = 8'h34;
    localparam logic [7:0]  OFS_SA6    = 8'h35;
    localparam logic [7:0]  OFS_STATUS = 8'h38;
    // reset values and masks
    localparam logic [7:0]  RST_ZERO   = 8'h00;
    localparam logic [7:0]  RST_SA     = 8'hFF;
    localparam logic [7:0]  CTRL2_MASK = 8'hCF;
    // select register fields
    localparam int          SEL_SA6    = 5;
    localparam int          SEL_SA5    = 4;
    localparam int          SEL_LB1    = 2;
    localparam int          SEL_LB2    = 1;
    localparam int          SEL_LBR    = 0;
    // control 1 fields
    localparam int          C1_SF1     = 7;
    localparam int          C1_SL1     = 6;
    localparam int          C1_SF2     = 5;
    localparam int          C1_SF3     = 4;
    localparam int          C1_SF4     = 3;
    localparam int          C1_PWR     = 2;
    localparam int          C1_PWRSF   = 1;
    localparam int          C1_AUX     = 0;
    // control 2 fields
    localparam int          C2_AIS1    = 7;
    localparam int          C2_AIS2    = 6;
    localparam int          C2_REP_HI  = 3;
    localparam int          C2_REP_LO  = 2;
    localparam int          C2_DET     = 1;
    localparam int          C2_BOTH    = 0;
    localparam logic [1:0]  REP_OFF    = 2'h0;
    localparam logic [1:0]  REP_1      = 2'h1;
    localparam logic [1:0]  REP_2      = 2'h2;
    localparam logic [1:0]  REP_3      = 2'h3;
    // overhead word layout
    localparam int          W_E        = 0;
    localparam int          W_A        = 2;
    localparam int          W_SA5      = 4;
    localparam int          W_SA6      = 5;
    localparam logic [2:0]  POS_LAST   = 3'h7;
    localparam logic [2:0]  POS_E_MIN  = 3'h6;
    // sequence patterns
    localparam logic [7:0]  PAT_ZERO   = 8'h00;
    localparam logic [7:0]  PAT_ONES   = 8'hFF;
    localparam logic [7:0]  PAT_ALT    = 8'hAA;
    // sa6 nibble codes
    localparam logic [3:0]  N_0000     = 4'h0;
    localparam logic [3:0]  N_0001     = 4'h1;
    localparam logic [3:0]  N_0010     = 4'h2;
    localparam logic [3:0]  N_0011     = 4'h3;
    localparam logic [3:0]  N_1000     = 4'h8;
    localparam logic [3:0]  N_1100     = 4'hC;
    localparam logic [3:0]  N_1110     = 4'hE;
    localparam logic [3:0]  N_1111     = 4'hF;
    // status fields
    localparam int          ST_LB      = 0;
    localparam int          ST_OVR     = 1;
    localparam int          ST_PWR     = 2;
    typedef enum logic {LB_OFF, LB_ON} lb_state_t;
endpackage : e1_nat_pkg

/* e1_national_bit_auto_response.sv */
// E1 transmit national-bit auto response and pattern loopback
// assumes upstream/downstream on clock; only power_loss is a pin
//
// How it works
// - pattern 1 for 8 multiframes enters loopback
// - pattern 2 for 8 multiframes enters loopback
// - zero Sa5/Sa6 for 8 multiframes releases
// - select bit 0 pin, 1 register
// - LOS/LFA response 1: Sa5 1, Sa6 0000
// - LOS response 1: A 1, Sa5 1, 1110
// - LOS/LFA response 2: A 1, Sa5 0, 0000
// - LOS/LFA response 3: A 0, Sa5 1, 1100
// - LOS/LFA response 4: A 0, Sa5 1, 1110
// - power loss high: A 0, Sa5 1, 1000
// - power plus LOS/LFA: A 1, Sa5 1, 1000
// - LOS auxiliary: Sa5/Sa6 send 10101010
// - AIS: Sa5 1, Sa6 1, A per enable
// - far-end error codes 01/10/11 select responses
// - CRC-4 error: A 0, Sa5 1, 0010, E 1
// - both errors: A 0, Sa5 1, 0011, E 1
`timescale 1ns/100ps
`default_nettype none
module e1_national_bit_auto_response #(
    parameter int MATCH_RUN = e1_nat_pkg::RUN_DEF
) (
    input  wire logic                           clock,
    input  wire logic                           nrst,
    input  wire logic [e1_nat_pkg::ADDR_W-1:0]  addr,
    input  wire logic [e1_nat_pkg::DATA_W-1:0]  wr_data,
    input  wire logic                           wr_strobe,
    input  wire logic                           rd_strobe,
    output logic      [e1_nat_pkg::DATA_W-1:0]  rd_data,
    input  wire logic                           in_valid,
    output logic                                in_ready,
    input  wire logic [7:0]                     tx_serial_in,
    input  wire logic [e1_nat_pkg::POS_W-1:0]   in_pos,
    output logic                                out_valid,
    input  wire logic                           out_ready,
    output logic      [7:0]                     out_word,
    output logic      [e1_nat_pkg::POS_W-1:0]   out_pos,
    input  wire logic                           los,
    input  wire logic                           lfa,
    input  wire logic                           ais,
    input  wire logic                           febe,
    input  wire logic                           crc_err,
    input  wire logic                           power_loss,
    output logic                                local_loopback
);
    localparam int RW = $clog2(MATCH_RUN + 1);
    localparam logic [RW-1:0] RUN_END = RW'(MATCH_RUN);

    if (MATCH_RUN < 1 || MATCH_RUN > 255) begin : g_chk
        $error("MATCH_RUN must lie in 1..255");
    end

    function automatic logic [RW-1:0] run_step(
        input logic [RW-1:0] run,
        input logic          hit
    );
        if (!hit) return '0;
        return (run == RUN_END) ? run : run + RW'(1);
    endfunction : run_step

    logic [7:0] sel_reg;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] sa5_reg;
    logic [7:0] sa6_reg;
    logic       pwr_s1;
    logic       pwr_s2;
    logic [7:0] sa5_sh;
    logic [7:0] sa6_sh;
    logic [7:0] a_sh;
    logic [RW-1:0] run1;
    logic [RW-1:0] run2;
    logic [RW-1:0] runr;
    e1_nat_pkg::lb_state_t lb_state;
    logic       ovr_seen;
    logic [7:0] sk_word;
    logic [2:0] sk_pos;
    logic       sk_valid;

    // power-loss pin, two flops before use
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pwr_s1 <= 1'b0;
            pwr_s2 <= 1'b0;
        end else begin
            pwr_s1 <= power_loss;
            pwr_s2 <= pwr_s1;
        end
    end

    // register writes
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sel_reg <= e1_nat_pkg::RST_ZERO;
            ctrl1   <= e1_nat_pkg::RST_ZERO;
            ctrl2   <= e1_nat_pkg::RST_ZERO;
            sa5_reg <= e1_nat_pkg::RST_SA;
            sa6_reg <= e1_nat_pkg::RST_SA;
        end else if (wr_strobe) begin
            unique case (addr)
                e1_nat_pkg::OFS_SEL:   sel_reg <= wr_data;
                e1_nat_pkg::OFS_CTRL1: ctrl1 <= wr_data;
                e1_nat_pkg::OFS_CTRL2: ctrl2 <= wr_data & e1_nat_pkg::CTRL2_MASK;
                e1_nat_pkg::OFS_SA5:   sa5_reg <= wr_data;
                e1_nat_pkg::OFS_SA6:   sa6_reg <= wr_data;
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_data <= '0;
        end else if (!rd_strobe) begin
            rd_data <= '0;
        end else begin
            unique case (addr)
                e1_nat_pkg::OFS_SEL:    rd_data <= sel_reg;
                e1_nat_pkg::OFS_CTRL1:  rd_data <= ctrl1;
                e1_nat_pkg::OFS_CTRL2:  rd_data <= ctrl2;
                e1_nat_pkg::OFS_SA5:    rd_data <= sa5_reg;
                e1_nat_pkg::OFS_SA6:    rd_data <= sa6_reg;
                e1_nat_pkg::OFS_STATUS: begin
                    rd_data <= '0;
                    rd_data[e1_nat_pkg::ST_LB]  <= local_loopback;
                    rd_data[e1_nat_pkg::ST_OVR] <= ovr_seen;
                    rd_data[e1_nat_pkg::ST_PWR] <= pwr_s2;
                end
                default: rd_data <= '0;
            endcase
        end
    end

    logic take, pop, last, from_pin;
    logic [7:0] sa5_mf, sa6_mf, a_mf;
    logic hit1, hit2, hitr, enter_now, release_now;
    logic [RW-1:0] next_run1, next_run2, next_runr;

    assign take = in_valid && in_ready;
    assign pop  = out_valid && out_ready;
    assign last = (in_pos == e1_nat_pkg::POS_LAST);
    // pattern checks only see pin-sourced Sa bits
    assign from_pin = !sel_reg[e1_nat_pkg::SEL_SA5]
                   && !sel_reg[e1_nat_pkg::SEL_SA6];
    assign sa5_mf = {sa5_sh[6:0], tx_serial_in[e1_nat_pkg::W_SA5]};
    assign sa6_mf = {sa6_sh[6:0], tx_serial_in[e1_nat_pkg::W_SA6]};
    assign a_mf   = {a_sh[6:0], tx_serial_in[e1_nat_pkg::W_A]};
    assign hit1 = from_pin && sa5_mf == e1_nat_pkg::PAT_ZERO
               && sa6_mf == e1_nat_pkg::PAT_ONES
               && a_mf == e1_nat_pkg::PAT_ONES;
    assign hit2 = from_pin && sa5_mf == e1_nat_pkg::PAT_ZERO
               && sa6_mf == e1_nat_pkg::PAT_ALT
               && a_mf == e1_nat_pkg::PAT_ONES;
    assign hitr = from_pin && sa5_mf == e1_nat_pkg::PAT_ZERO
               && sa6_mf == e1_nat_pkg::PAT_ZERO;
    assign next_run1 = run_step(run1, hit1);
    assign next_run2 = run_step(run2, hit2);
    assign next_runr = run_step(runr, hitr);
    assign enter_now = take && last
        && ((sel_reg[e1_nat_pkg::SEL_LB1] && next_run1 == RUN_END)
         || (sel_reg[e1_nat_pkg::SEL_LB2] && next_run2 == RUN_END));
    assign release_now = take && last && sel_reg[e1_nat_pkg::SEL_LBR]
        && next_runr == RUN_END;

    // per-multiframe sequence capture and run counts
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sa5_sh <= '0;
            sa6_sh <= '0;
            a_sh   <= '0;
            run1   <= '0;
            run2   <= '0;
            runr   <= '0;
        end else if (take) begin
            sa5_sh <= sa5_mf;
            sa6_sh <= sa6_mf;
            a_sh   <= a_mf;
            if (last) begin
                run1 <= next_run1;
                run2 <= next_run2;
                runr <= next_runr;
            end
        end
    end

    // activation wins over release when both complete together
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lb_state       <= e1_nat_pkg::LB_OFF;
            local_loopback <= 1'b0;
        end else begin
            unique case (lb_state)
                e1_nat_pkg::LB_OFF: if (enter_now) begin
                    lb_state       <= e1_nat_pkg::LB_ON;
                    local_loopback <= 1'b1;
                end
                e1_nat_pkg::LB_ON: if (release_now && !enter_now) begin
                    lb_state       <= e1_nat_pkg::LB_OFF;
                    local_loopback <= 1'b0;
                end
            endcase
        end
    end

    // overhead override, highest priority first
    logic sf;
    logic [1:0] rep;
    logic [1:0] nib;
    logic aux_bit;
    logic ovr;
    logic [3:0] s6n;
    logic [7:0] w;

    assign sf  = los || lfa;
    assign rep = {ctrl2[e1_nat_pkg::C2_REP_HI], ctrl2[e1_nat_pkg::C2_REP_LO]};
    assign nib = 2'(3 - {1'b0, in_pos[1:0]});
    assign aux_bit = !in_pos[0];

    always_comb begin
        // normal sources first
        w = tx_serial_in;
        if (sel_reg[e1_nat_pkg::SEL_SA5])
            w[e1_nat_pkg::W_SA5] = sa5_reg[3'(7 - in_pos)];
        if (sel_reg[e1_nat_pkg::SEL_SA6])
            w[e1_nat_pkg::W_SA6] = sa6_reg[3'(7 - in_pos)];
        ovr = 1'b1;
        s6n = e1_nat_pkg::N_0000;
        if (pwr_s2 && sf && ctrl1[e1_nat_pkg::C1_PWRSF]) begin
            w[e1_nat_pkg::W_A] = 1'b1;
            w[e1_nat_pkg::W_SA5] = 1'b1;
            s6n = e1_nat_pkg::N_1000;
        end else if (pwr_s2 && ctrl1[e1_nat_pkg::C1_PWR]) begin
            w[e1_nat_pkg::W_A] = 1'b0;
            w[e1_nat_pkg::W_SA5] = 1'b1;
            s6n = e1_nat_pkg::N_1000;
        end else if (los && ctrl1[e1_nat_pkg::C1_SL1]) begin
            w[e1_nat_pkg::W_A] = 1'b1;
            w[e1_nat_pkg::W_SA5] = 1'b1;
            s6n = e1_nat_pkg::N_1110;
        end else if (los && ctrl1[e1_nat_pkg::C1_AUX]) begin
            w[e1_nat_pkg::W_SA5] = aux_bit;
            s6n = aux_bit ? e1_nat_pkg::N_1111 : e1_nat_pkg::N_0000;
        end else if (sf && ctrl1[e1_nat_pkg::C1_SF1]) begin
            w[e1_nat_pkg::W_SA5] = 1'b1;
            s6n = e1_nat_pkg::N_0000;
        end else if (sf && ctrl1[e1_nat_pkg::C1_SF2]) begin
            w[e1_nat_pkg::W_A] = 1'b1;
            w[e1_nat_pkg::W_SA5] = 1'b0;
            s6n = e1_nat_pkg::N_0000;
        end else if (sf && ctrl1[e1_nat_pkg::C1_SF3]) begin
            w[e1_nat_pkg::W_A] = 1'b0;
            w[e1_nat_pkg::W_SA5] = 1'b1;
            s6n = e1_nat_pkg::N_1100;
        end else if (sf && ctrl1[e1_nat_pkg::C1_SF4]) begin
            w[e1_nat_pkg::W_A] = 1'b0;
            w[e1_nat_pkg::W_SA5] = 1'b1;
            s6n = e1_nat_pkg::N_1110;
        end else if (ais && (ctrl2[e1_nat_pkg::C2_AIS1]
                          || ctrl2[e1_nat_pkg::C2_AIS2])) begin
            w[e1_nat_pkg::W_A] = ctrl2[e1_nat_pkg::C2_AIS1];
            w[e1_nat_pkg::W_SA5] = 1'b1;
            s6n = e1_nat_pkg::N_1111;
        end else if (febe && crc_err && ctrl2[e1_nat_pkg::C2_BOTH]) begin
            w[e1_nat_pkg::W_A] = 1'b0;
            w[e1_nat_pkg::W_SA5] = 1'b1;
            s6n = e1_nat_pkg::N_0011;
            if (in_pos >= e1_nat_pkg::POS_E_MIN) w[e1_nat_pkg::W_E] = 1'b1;
        end else if (crc_err && ctrl2[e1_nat_pkg::C2_DET]) begin
            w[e1_nat_pkg::W_A] = 1'b0;
            w[e1_nat_pkg::W_SA5] = 1'b1;
            s6n = e1_nat_pkg::N_0010;
            if (in_pos >= e1_nat_pkg::POS_E_MIN) w[e1_nat_pkg::W_E] = 1'b1;
        end else if (febe && rep != e1_nat_pkg::REP_OFF) begin
            w[e1_nat_pkg::W_A] = 1'b0;
            w[e1_nat_pkg::W_SA5] = (rep != e1_nat_pkg::REP_2);
            s6n = (rep == e1_nat_pkg::REP_3) ? e1_nat_pkg::N_0001
                                             : e1_nat_pkg::N_0000;
            if (in_pos >= e1_nat_pkg::POS_E_MIN)
                w[e1_nat_pkg::W_E] = (rep == e1_nat_pkg::REP_3);
        end else begin
            ovr = 1'b0;
        end
        if (ovr)
            w[e1_nat_pkg::W_SA6] = s6n[nib];
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ovr_seen <= 1'b0;
        end else begin
            ovr_seen <= ovr;
        end
    end

    // two-entry skid buffer; ready drops only when both slots hold words
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            out_valid <= 1'b0;
            out_word  <= '0;
            out_pos   <= '0;
            sk_valid  <= 1'b0;
            sk_word   <= '0;
            sk_pos    <= '0;
            in_ready  <= 1'b1;
        end else begin
            if (pop) begin
                if (sk_valid) begin
                    out_word <= sk_word;
                    out_pos  <= sk_pos;
                    sk_valid <= 1'b0;
                    in_ready <= 1'b1;
                end else if (take) begin
                    out_word <= w;
                    out_pos  <= in_pos;
                end else begin
                    out_valid <= 1'b0;
                end
            end else if (take) begin
                if (!out_valid) begin
                    out_word  <= w;
                    out_pos   <= in_pos;
                    out_valid <= 1'b1;
                end else begin
                    sk_word  <= w;
                    sk_pos   <= in_pos;
                    sk_valid <= 1'b1;
                    in_ready <= 1'b0;
                end
            end
        end
    end

    property p_enter;
        @(posedge clock) disable iff (!nrst)
        enter_now |=> local_loopback;
    endproperty
    a_enter: assert property (p_enter) else $error("loopback not entered");
    property p_pat2;
        @(posedge clock) disable iff (!nrst)
        take && last && sel_reg[e1_nat_pkg::SEL_LB2] && !local_loopback
        && next_run2 == RUN_END |=> local_loopback;
    endproperty
    a_pat2: assert property (p_pat2) else $error("pattern 2 missed");
    property p_release;
        @(posedge clock) disable iff (!nrst)
        release_now && !enter_now |=> !local_loopback;
    endproperty
    a_release: assert property (p_release) else $error("no release");
    property p_lb_cause;
        @(posedge clock) disable iff (!nrst)
        $changed(local_loopback) |-> $past(enter_now || release_now);
    endproperty
    a_lb_cause: assert property (p_lb_cause) else $error("loopback moved alone");
    property p_pwr_sf;
        @(posedge clock) disable iff (!nrst)
        pwr_s2 && sf && ctrl1[e1_nat_pkg::C1_PWRSF]
        |-> w[e1_nat_pkg::W_A] && w[e1_nat_pkg::W_SA5]
            && w[e1_nat_pkg::W_SA6] == (in_pos[1:0] == 2'h0);
    endproperty
    a_pwr_sf: assert property (p_pwr_sf) else $error("power+loss code wrong");
    property p_crc;
        @(posedge clock) disable iff (!nrst)
        take && crc_err && ctrl2[e1_nat_pkg::C2_DET] && !pwr_s2 && !sf
        && !ais && !febe && !out_valid
        |=> out_valid && !out_word[e1_nat_pkg::W_A]
            && out_word[e1_nat_pkg::W_SA5];
    endproperty
    a_crc: assert property (p_crc) else $error("crc response wrong");
    property p_no_ovr;
        @(posedge clock) disable iff (!nrst)
        !pwr_s2 && !sf && !ais && !febe && !crc_err |-> !ovr;
    endproperty
    a_no_ovr: assert property (p_no_ovr) else $error("spurious override");
    property p_stall;
        @(posedge clock) disable iff (!nrst)
        out_valid && !out_ready |=> out_valid && $stable(out_word);
    endproperty
    a_stall: assert property (p_stall) else $error("word lost on stall");
    property p_full;
        @(posedge clock) disable iff (!nrst)
        sk_valid |-> !in_ready && out_valid;
    endproperty
    a_full: assert property (p_full) else $error("buffer full but ready");
    property p_status;
        @(posedge clock) disable iff (!nrst)
        rd_strobe && addr == e1_nat_pkg::OFS_STATUS
        |=> rd_data[e1_nat_pkg::ST_LB] == $past(local_loopback);
    endproperty
    a_status: assert property (p_status) else $error("status read wrong");
endmodule : e1_national_bit_auto_response
`default_nettype wire

/* e1_line_sink.sv */
// line-side sink model taking transmitted overhead words
// assumes one clock; hold stalls fully, slow stalls every other cycle
`timescale 1ns/100ps
`default_nettype none
module e1_line_sink (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic hold,
    input  wire logic slow,
    output logic      out_ready
);
    logic phase;
    // registered ready, so a stall never lands in the edge that raised it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            phase     <= 1'b0;
            out_ready <= 1'b0;
        end else begin
            phase     <= ~phase;
            out_ready <= ~hold & ~(slow & phase);
        end
    end
endmodule : e1_line_sink
`default_nettype wire

/* e1_national_bit_auto_response_test.sv */
// self-checking bench for the national-bit auto-response block
// assumes the line sink model; pattern runs shortened through MATCH_RUN
`timescale 1ns/100ps
`default_nettype none
module e1_national_bit_auto_response_test;
    localparam int RUN = 2;
    logic        clock        = 1'b0;
    logic        nrst         = 1'b0;
    logic [7:0]  addr         = 8'h00;
    logic [7:0]  wr_data      = 8'h00;
    logic        wr_strobe    = 1'b0;
    logic        rd_strobe    = 1'b0;
    logic        in_valid     = 1'b0;
    logic [7:0]  tx_serial_in = 8'h00;
    logic [2:0]  in_pos       = 3'h0;
    logic [5:0]  cond         = 6'h00;
    logic        hold         = 1'b0;
    logic        slow         = 1'b0;
    logic [7:0]  rd_data;
    logic        in_ready;
    logic        out_valid;
    logic        out_ready;
    logic [7:0]  out_word;
    logic [2:0]  out_pos;
    logic        local_loopback;
    logic [10:0] q[$];
    int          error_cnt    = 0;
    int          total_checks = 0;

    always #2 clock = ~clock;
    always @(posedge clock) if (out_valid && out_ready) q.push_back({out_pos, out_word});

    e1_national_bit_auto_response #(.MATCH_RUN(RUN)) DUT (
        .clock(clock), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rd_data(rd_data), .in_valid(in_valid), .in_ready(in_ready),
        .tx_serial_in(tx_serial_in), .in_pos(in_pos), .out_valid(out_valid),
        .out_ready(out_ready), .out_word(out_word), .out_pos(out_pos), .los(cond[4]),
        .lfa(cond[3]), .ais(cond[2]), .febe(cond[1]), .crc_err(cond[0]),
        .power_loss(cond[5]), .local_loopback(local_loopback));
    e1_line_sink SINK (.clock(clock), .nrst(nrst), .hold(hold), .slow(slow),
        .out_ready(out_ready));

    task stop_test();
        if (error_cnt == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    task timeout();
        error_cnt++;
        stop_test();
    endtask : timeout

    task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // strobe lowered and one edge let pass, so back-to-back calls never collide
    task wr(input logic [7:0] a, input logic [7:0] d);
        addr      <= a;
        wr_data   <= d;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
        @(posedge clock);
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] d);
        addr      <= a;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
        @(posedge clock);
        d = rd_data;
    endtask : rd

    task rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check("rd_data", d, exp);
    endtask : rchk

    task wait_q(input int n);
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (q.size() < n && k < 200);
        if (q.size() < n) timeout();
    endtask : wait_q

    task put(input logic [7:0] w, input logic [2:0] p);
        int n;
        n            = 0;
        in_valid     <= 1'b1;
        tx_serial_in <= w;
        in_pos       <= p;
        @(posedge clock);
        while (in_ready !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        if (in_ready !== 1'b1) timeout();
    endtask : put

    // one multiframe, sequences sent msb first in pos order
    task mf(input logic [7:0] b, input logic [7:0] pa, input logic [7:0] p5,
            input logic [7:0] p6);
        logic [7:0] w;
        int         p;
        q.delete();
        for (p = 0; p < 8; p++) begin
            w = b;
            w[e1_nat_pkg::W_A] = pa[7-p];
            w[e1_nat_pkg::W_SA5] = p5[7-p];
            w[e1_nat_pkg::W_SA6] = p6[7-p];
            put(w, p[2:0]);
        end
        in_valid <= 1'b0;
        wait_q(8);
    endtask : mf

    // am/em 2 keeps the pin value; s5 2 is the alternating pattern, 3 keeps
    task run_case(input logic [7:0] c1, input logic [7:0] c2, input logic [5:0] cn,
                  input logic [1:0] am, input logic [1:0] s5, input logic [3:0] nb,
                  input logic [1:0] em);
        logic [7:0] e;
        int         p;
        wr(e1_nat_pkg::OFS_CTRL1, c1);
        wr(e1_nat_pkg::OFS_CTRL2, c2);
        cond <= cn;
        repeat (4) @(posedge clock);
        mf(8'h5B, 8'h00, 8'hFF, 8'h00);
        for (p = 0; p < 8; p++) begin
            e = 8'h5B;
            if (am != 2'h2) e[e1_nat_pkg::W_A] = am[0];
            if (s5 == 2'h2) begin
                e[e1_nat_pkg::W_SA5] = ~p[0];
                e[e1_nat_pkg::W_SA6] = ~p[0];
            end else if (s5 != 2'h3) begin
                e[e1_nat_pkg::W_SA5] = s5[0];
                e[e1_nat_pkg::W_SA6] = nb[3 - p % 4];
            end
            if (em != 2'h2 && p >= 6) e[e1_nat_pkg::W_E] = em[0];
            check("out_word", q[p][7:0], e);
        end
        cond <= 6'h00;
    endtask : run_case

    task lb_chk(input logic x);
        logic [7:0] d;
        rd(e1_nat_pkg::OFS_STATUS, d);
        check("status", {7'h00, d[e1_nat_pkg::ST_LB]}, {7'h00, x});
        check("local_loopback", {7'h00, local_loopback}, {7'h00, x});
    endtask : lb_chk

    task lb_case();
        wr(e1_nat_pkg::OFS_SEL, 8'h14);
        mf(8'h00, 8'hFF, 8'h00, 8'hFF);
        mf(8'h00, 8'hFF, 8'h00, 8'hFF);
        lb_chk(1'b0);
        wr(e1_nat_pkg::OFS_SEL, 8'h04);
        mf(8'h00, 8'hFF, 8'h00, 8'hFF);
        lb_chk(1'b0);
        mf(8'h00, 8'hFF, 8'h00, 8'hFF);
        lb_chk(1'b1);
        wr(e1_nat_pkg::OFS_SEL, 8'h01);
        mf(8'h00, 8'h00, 8'h00, 8'h00);
        lb_chk(1'b1);
        mf(8'h00, 8'h00, 8'h00, 8'h00);
        lb_chk(1'b0);
        wr(e1_nat_pkg::OFS_SEL, 8'h02);
        mf(8'h00, 8'hFF, 8'h00, 8'hAA);
        mf(8'h00, 8'hFF, 8'h00, 8'hFF);
        mf(8'h00, 8'hFF, 8'h00, 8'hAA);
        lb_chk(1'b0);
        mf(8'h00, 8'hFF, 8'h00, 8'hAA);
        lb_chk(1'b1);
    endtask : lb_case

    task stall_case();
        int n;
        int p;
        // receiver stalled: the two-entry buffer must refuse the third word
        hold <= 1'b1;
        q.delete();
        n = 0;
        in_valid     <= 1'b1;
        tx_serial_in <= 8'h00;
        in_pos       <= 3'h0;
        repeat (12) begin
            @(posedge clock);
            if (in_ready === 1'b1) begin
                n++;
                in_pos <= n[2:0];
            end
        end
        check("taken", n[7:0], 8'h02);
        hold <= 1'b0;
        for (p = 2; p < 8; p++) put(8'h00, p[2:0]);
        in_valid <= 1'b0;
        wait_q(8);
        for (p = 0; p < 8; p++) check("out_pos", {5'h00, q[p][10:8]}, p[7:0]);
    endtask : stall_case

    initial begin
        logic [7:0] r5;
        logic [7:0] r6;
        int         p;
        r5 = 8'hA5;
        r6 = 8'h3C;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rchk(e1_nat_pkg::OFS_SEL, e1_nat_pkg::RST_ZERO);
        rchk(e1_nat_pkg::OFS_CTRL1, e1_nat_pkg::RST_ZERO);
        rchk(e1_nat_pkg::OFS_CTRL2, e1_nat_pkg::RST_ZERO);
        rchk(e1_nat_pkg::OFS_SA5, e1_nat_pkg::RST_SA);
        rchk(e1_nat_pkg::OFS_SA6, e1_nat_pkg::RST_SA);
        rchk(8'h3F, 8'h00);
        wr(e1_nat_pkg::OFS_CTRL2, 8'hFF);
        rchk(e1_nat_pkg::OFS_CTRL2, e1_nat_pkg::CTRL2_MASK);
        wr(e1_nat_pkg::OFS_SEL, 8'h30);
        wr(e1_nat_pkg::OFS_SA5, r5);
        wr(e1_nat_pkg::OFS_SA6, r6);
        mf(8'h00, 8'h00, 8'h00, 8'h00);
        for (p = 0; p < 8; p++) check("sa_src", q[p][7:0], {2'h0, r6[7-p], r5[7-p], 4'h0});
        wr(e1_nat_pkg::OFS_SEL, 8'h00);
        slow <= 1'b1;
        run_case(8'h80, 8'h00, 6'h08, 2'h2, 2'h1, 4'h0, 2'h2);
        run_case(8'h40, 8'h00, 6'h10, 2'h1, 2'h1, 4'hE, 2'h2);
        run_case(8'h20, 8'h00, 6'h08, 2'h1, 2'h0, 4'h0, 2'h2);
        run_case(8'h10, 8'h00, 6'h10, 2'h0, 2'h1, 4'hC, 2'h2);
        run_case(8'h08, 8'h00, 6'h08, 2'h0, 2'h1, 4'hE, 2'h2);
        run_case(8'h04, 8'h00, 6'h20, 2'h0, 2'h1, 4'h8, 2'h2);
        run_case(8'h04, 8'h00, 6'h00, 2'h2, 2'h3, 4'h0, 2'h2);
        run_case(8'h02, 8'h00, 6'h28, 2'h1, 2'h1, 4'h8, 2'h2);
        run_case(8'h01, 8'h00, 6'h10, 2'h2, 2'h2, 4'h0, 2'h2);
        run_case(8'h00, 8'h80, 6'h04, 2'h1, 2'h1, 4'hF, 2'h2);
        run_case(8'h00, 8'h40, 6'h04, 2'h0, 2'h1, 4'hF, 2'h2);
        run_case(8'h00, 8'h04, 6'h02, 2'h0, 2'h1, 4'h0, 2'h0);
        run_case(8'h00, 8'h08, 6'h02, 2'h0, 2'h0, 4'h0, 2'h0);
        run_case(8'h00, 8'h0C, 6'h02, 2'h0, 2'h1, 4'h1, 2'h1);
        run_case(8'h00, 8'h02, 6'h01, 2'h0, 2'h1, 4'h2, 2'h1);
        run_case(8'h00, 8'h01, 6'h03, 2'h0, 2'h1, 4'h3, 2'h1);
        run_case(8'h00, 8'h00, 6'h02, 2'h2, 2'h3, 4'h0, 2'h2);
        run_case(8'h80, 8'h0C, 6'h00, 2'h2, 2'h3, 4'h0, 2'h2);
        slow <= 1'b0;
        lb_case();
        stall_case();
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        check("local_loopback", {7'h00, local_loopback}, 8'h00);
        nrst <= 1'b1;
        @(posedge clock);
        rchk(e1_nat_pkg::OFS_SEL, e1_nat_pkg::RST_ZERO);
        stop_test();
    end
endmodule : e1_national_bit_auto_response_test
`default_nettype wire
